// file: exec_pkg.sv
// Purpose: shared constants and types for the instruction executer
// Assumes: 32-bit classic wishbone register bus, word-aligned byte offsets
// Notes: file registers are reached through a window of words

package exec_pkg;

  // ***************************************************
  // widths
  // ***************************************************
  localparam int DATA_W = 8;
  localparam int PC_W = 11;
  localparam int FILE_N = 32;
  localparam int STACK_N = 2;

  // ***************************************************
  // register byte offsets
  // ***************************************************
  localparam logic [7:0] INSTR_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] PC_OFS = 8'h0C;
  localparam logic [7:0] WDOG_OFS = 8'h10;
  localparam logic [7:0] STACK_OFS = 8'h14;
  localparam logic [7:0] EXEC_OFS = 8'h18;
  localparam logic [7:0] FILE_OFS = 8'h80;

  // ***************************************************
  // instruction word fields
  // ***************************************************
  localparam int OP_LSB = 0;
  localparam int FADR_LSB = 8;
  localparam int DEST_BIT = 13;
  localparam int BSEL_LSB = 16;
  localparam int LIT_LSB = 24;

  // ***************************************************
  // status bits and watchdog control bits
  // ***************************************************
  localparam int ZERO_BIT = 2;
  localparam int SLEEP_BIT = 3;
  localparam int EXPIRY_BIT = 4;
  localparam int PAGE_LSB = 5;
  localparam int PRESC_LSB = 8;
  localparam int ASSIGN_BIT = 16;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] ZERO_VAL = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;
  localparam logic ASSIGN_RST = 1'b1;

  // ***************************************************
  // instruction cycle counts
  // ***************************************************
  localparam logic [1:0] ONE_CYCLE = 2'h1;
  localparam logic [1:0] TWO_CYCLE = 2'h2;

  typedef enum logic [2:0] {
    and_accumulator_file = 3'h0,
    bit_test_skip_clear = 3'h1,
    bit_test_skip_set = 3'h2,
    clear_accumulator_op = 3'h3,
    clear_file_op = 3'h4,
    call_op = 3'h5,
    watchdog_kick_op = 3'h6,
    idle_op = 3'h7
  } op_t;

endpackage

// file: file_ram.sv
// Purpose: file register storage with registered read data
// Assumes: one write and one read per cycle
// Notes: read data appear one edge after the address

`timescale 1ns/1ns

module file_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("file_ram: bad size");
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem[rd_addr_i];
    end
  end

endmodule

// file: instr_exec.sv
// Purpose: executes a subset of an 8-bit core's instructions
// Assumes: software writes one instruction word at a time
// Notes: one file read clock, then one clock per instruction cycle; skips and calls add one
//
// The register addresses and register access over Wishbone are this design's own decisions.

`timescale 1ns/1ns

// Functional notes
// - and accumulator with file; destination bit picks accumulator or file
// - skip-if-clear discards next instruction when bit is 0, 2 cycles
// - skip-if-set discards next instruction when bit is 1, 2 cycles
// - bit tests change no flags; file addresses 0 to 31
// - clear accumulator loads 00h and sets zero flag
// - clear file writes 00h to the file register, sets zero flag
// - call pushes program counter plus one before changing it
// - call loads literal low, clears bit 8, page bits to 10:9
// - call leaves all condition flags unchanged
// - watchdog kick resets the watchdog counter to 00h
// - watchdog kick clears prescaler only when assigned to watchdog
// - watchdog kick sets expiry flag and sleep entry flag to 1
module instr_exec
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = exec_pkg::STACK_N
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o
);

  import exec_pkg::*;

  initial begin
    if (STACK_DEPTH < 1 || STACK_DEPTH > 255) begin
      $error("instr_exec: bad stack depth");
    end
  end

  // ***************************************************
  // declarations
  // ***************************************************
  typedef enum logic [1:0] {
    st_idle,
    st_read,
    st_exec,
    st_discard
  } state_t;

  state_t state;
  op_t op;
  logic [4:0] fadr;
  logic dest;
  logic [2:0] bsel;
  logic [7:0] lit;
  logic [7:0] acc;
  logic [7:0] status;
  logic [PC_W-1:0] pc;
  logic [7:0] wdog;
  logic [7:0] presc;
  logic assign_wdog;
  logic last_skip;
  logic [1:0] last_cycles;
  logic file_wait;
  logic req;
  logic file_rd;
  logic go;
  logic wr_go;
  logic [7:0] fdata;
  logic [7:0] and_res;
  logic bit_val;
  logic skip;
  logic kick;
  logic ram_we;
  logic [4:0] ram_wa;
  logic [7:0] ram_wd;
  logic [4:0] ram_ra;
  logic [PC_W-1:0] stack_top;
  logic [7:0] stack_fill;
  logic push;
  logic [31:0] rd_mux;
  logic in_exec;

  // ***************************************************
  // bus decode
  // ***************************************************
  assign req = cyc_i && stb_i && !ack_o;
  assign file_rd = adr_i[7] && !we_i;
  assign go = req && state == st_idle && (!file_rd || file_wait);
  assign wr_go = go && we_i;
  assign in_exec = state == st_exec;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_wait <= 1'b0;
    end else begin
      file_wait <= req && state == st_idle && file_rd && !file_wait;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= go;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (adr_i[7]) begin
      rd_mux = {24'h000000, fdata};
    end else begin
      case ({adr_i[7:2], 2'b00})
        ACC_OFS: rd_mux = {24'h000000, acc};
        STATUS_OFS: rd_mux = {24'h000000, status};
        PC_OFS: rd_mux = {21'h000000, pc};
        WDOG_OFS: rd_mux = {15'h0000, assign_wdog, presc, wdog};
        STACK_OFS: rd_mux = {13'h0000, stack_fill, stack_top};
        EXEC_OFS: rd_mux = {29'h00000000, last_skip, last_cycles};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (go && !we_i) begin
      dat_o <= rd_mux;
    end
  end

  // ***************************************************
  // instruction capture and sequencing
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op <= idle_op;
      fadr <= 5'h00;
      dest <= 1'b0;
      bsel <= 3'h0;
      lit <= 8'h00;
    end else if (wr_go && {adr_i[7:2], 2'b00} == INSTR_OFS
                 && sel_i == 4'hF) begin
      op <= op_t'(dat_i[OP_LSB +: 3]);
      fadr <= dat_i[FADR_LSB +: 5];
      dest <= dat_i[DEST_BIT];
      bsel <= dat_i[BSEL_LSB +: 3];
      lit <= dat_i[LIT_LSB +: 8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (wr_go && {adr_i[7:2], 2'b00} == INSTR_OFS && sel_i == 4'hF) begin
            state <= st_read;
          end
        end
        st_read: state <= st_exec;
        st_exec: begin
          if (skip || op == call_op) begin
            state <= st_discard;
          end else begin
            state <= st_idle;
          end
        end
        st_discard: state <= st_idle;
        default: state <= st_idle;
      endcase
    end
  end

  // ***************************************************
  // datapath
  // ***************************************************
  assign and_res = acc & fdata;
  assign bit_val = fdata[bsel];
  assign skip = in_exec && ((op == bit_test_skip_clear && !bit_val)
                || (op == bit_test_skip_set && bit_val));
  assign kick = in_exec && op == watchdog_kick_op;
  assign push = in_exec && op == call_op;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_skip <= 1'b0;
      last_cycles <= ONE_CYCLE;
    end else if (in_exec) begin
      last_skip <= skip;
      last_cycles <= (skip || op == call_op) ? TWO_CYCLE : ONE_CYCLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc <= ZERO_VAL;
    end else if (in_exec && op == and_accumulator_file && !dest) begin
      acc <= and_res;
    end else if (in_exec && op == clear_accumulator_op) begin
      acc <= ZERO_VAL;
    end else if (wr_go && {adr_i[7:2], 2'b00} == ACC_OFS && sel_i[0]) begin
      acc <= dat_i[7:0];
    end
  end

  // ***************************************************
  // status register
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= STATUS_RST;
    end else if (in_exec) begin
      case (op)
        and_accumulator_file: begin
          status[ZERO_BIT] <= and_res == ZERO_VAL;
        end
        clear_accumulator_op: status[ZERO_BIT] <= 1'b1;
        clear_file_op: status[ZERO_BIT] <= 1'b1;
        watchdog_kick_op: begin
          status[EXPIRY_BIT] <= 1'b1;
          status[SLEEP_BIT] <= 1'b1;
        end
        default: status <= status;
      endcase
    end else begin
      if (wr_go && {adr_i[7:2], 2'b00} == STATUS_OFS && sel_i[0]) begin
        status <= dat_i[7:0];
      end
      // wrap clears expiry even when a write lands
      if (wdog == 8'hFF && (!assign_wdog || presc == 8'hFF)) begin
        status[EXPIRY_BIT] <= 1'b0;
      end
    end
  end

  // ***************************************************
  // program counter and return stack
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc <= PC_RST;
    end else if (push) begin
      pc <= {status[PAGE_LSB +: 2], 1'b0, lit};
    end else if (in_exec || (state == st_discard && op != call_op)) begin
      pc <= pc + 11'h001;
    end else if (wr_go && {adr_i[7:2], 2'b00} == PC_OFS
                 && sel_i[1:0] == 2'h3) begin
      pc <= dat_i[PC_W-1:0];
    end
  end

  return_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(PC_W)
  ) u_stack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .push_i(push),
    .data_i(pc + 11'h001),
    .top_o(stack_top),
    .fill_o(stack_fill)
  );

  // ***************************************************
  // file registers
  // ***************************************************
  always_comb begin
    ram_we = 1'b0;
    ram_wa = adr_i[6:2];
    ram_wd = dat_i[7:0];
    if (in_exec && op == and_accumulator_file && dest) begin
      ram_we = 1'b1;
      ram_wa = fadr;
      ram_wd = and_res;
    end else if (in_exec && op == clear_file_op) begin
      ram_we = 1'b1;
      ram_wa = fadr;
      ram_wd = ZERO_VAL;
    end else if (wr_go && adr_i[7] && sel_i[0]) begin
      ram_we = 1'b1;
    end
  end

  assign ram_ra = (state == st_idle) ? adr_i[6:2] : fadr;

  file_ram #(
    .DEPTH(FILE_N),
    .WIDTH(DATA_W)
  ) u_file (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_en_i(ram_we),
    .wr_addr_i(ram_wa),
    .wr_data_i(ram_wd),
    .rd_addr_i(ram_ra),
    .rd_data_o(fdata)
  );

  // ***************************************************
  // watchdog counter and prescaler
  // ***************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assign_wdog <= ASSIGN_RST;
    end else if (wr_go && {adr_i[7:2], 2'b00} == WDOG_OFS && sel_i[2]) begin
      assign_wdog <= dat_i[ASSIGN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      presc <= 8'h00;
    end else if (kick && assign_wdog) begin
      presc <= 8'h00;
    end else begin
      presc <= presc + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wdog <= 8'h00;
    end else if (kick) begin
      wdog <= ZERO_VAL;
    end else if (!assign_wdog || presc == 8'hFF) begin
      wdog <= wdog + 8'h01;
    end
  end

endmodule

// file: instr_exec_chk.sv
// Purpose: bus and readback checks for the instruction executer
// Assumes: classic wishbone master, one request at a time
// Notes: bound to every instr_exec instance

`timescale 1ns/1ns

module instr_exec_chk
  import exec_pkg::*;
#(
  parameter int STACK_DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o
);
  // ***************************************************
  // properties
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    $rose(cyc_i && stb_i);
  endsequence
  sequence s_rd_ack;
    ack_o && !we_i;
  endsequence
  a_ack_bounded: assert property (s_start |-> ##[1:6] ack_o)
    else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  a_ack_in_req: assert property (ack_o |-> cyc_i && stb_i)
    else $error("ack without request");
  a_instr_reads_zero: assert property (
    s_rd_ack ##0 adr_i == INSTR_OFS |-> dat_o == 32'h0)
    else $error("instr read not zero");
  a_skip_two_cycles: assert property (
    s_rd_ack ##0 adr_i == EXEC_OFS
    |-> dat_o[31:3] == 0 && (!dat_o[2] || dat_o[1:0] == TWO_CYCLE))
    else $error("skip cycle count");
  a_pc_width: assert property (
    s_rd_ack ##0 adr_i == PC_OFS |-> dat_o[31:11] == 0)
    else $error("pc upper bits");
  a_file_byte: assert property (
    s_rd_ack ##0 adr_i[7] |-> dat_o[31:8] == 0)
    else $error("file read width");
  a_unmapped_zero: assert property (s_rd_ack ##0
    (!adr_i[7] && adr_i[6:2] > 5'h6) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_stack_fill: assert property (
    s_rd_ack ##0 adr_i == STACK_OFS
    |-> dat_o[31:19] == 0 && dat_o[18:11] <= STACK_DEPTH)
    else $error("stack fill range");
endmodule

bind instr_exec instr_exec_chk #(.STACK_DEPTH(STACK_DEPTH)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o));

// file: return_stack.sv
// Purpose: hardware return stack, push only from this block
// Assumes: a push beyond the depth drops the oldest entry
// Notes: the top entry is always entry 0

`timescale 1ns/1ns

module return_stack #(
  parameter int DEPTH = 2,
  parameter int WIDTH = 11
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // push side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] data_i,
  // view
  output logic [WIDTH-1:0] top_o,
  output logic [7:0] fill_o
);

  logic [WIDTH-1:0] entry [DEPTH];

  initial begin
    if (DEPTH < 1 || DEPTH > 255) begin
      $error("return_stack: bad depth");
    end
  end

  // ***************************************************
  // shift register of entries
  // ***************************************************
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        entry[i] <= '0;
      end else if (push_i) begin
        entry[i] <= (i == 0) ? data_i : entry[(i == 0) ? 0 : i-1];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fill_o <= 8'h00;
    end else if (push_i && fill_o < 8'(DEPTH)) begin
      fill_o <= fill_o + 8'h01;
    end
  end

  assign top_o = entry[0];

endmodule

// file: tb.sv
// Purpose: self-checking bench for the instruction executer
// Assumes: registers reached over classic wishbone
// Notes: random operands from a fixed seed

`timescale 1ns/1ns

module tb;
  import exec_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, rd;
  logic ack_o, d, s;
  logic [7:0] acc, v, k, st, fv[FILE_N];
  logic [10:0] pc;
  logic [4:0] f;
  logic [1:0] pg;
  op_t op;
  int error_cnt = 0, checks = 0, seed = 19, i, fill;

  always #10 clk_i = ~clk_i;

  instr_exec uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));

  // ***************************************************
  // helpers
  // ***************************************************
  task final_report;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dt,
    input logic [3:0] sl);
    int n;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= dt;
    sel_i <= sl;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      final_report;
    end
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    we_i <= 0;
    @(posedge clk_i);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dt);
    wb(1'b1, a, dt, 4'hF);
  endtask
  task rdv(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hF);
  endtask
  function automatic logic [31:0] ins(op_t o, logic [4:0] fa, logic de,
    logic [2:0] b, logic [7:0] lit);
    return {lit, 5'h0, b, 2'h0, de, fa, 5'h0, o};
  endfunction
  function automatic logic [7:0] fadr(logic [4:0] fa);
    return FILE_OFS + {1'b0, fa, 2'h0};
  endfunction
  function automatic logic zf(logic [7:0] x);
    return x == 8'h00;
  endfunction

  // ***************************************************
  // sequence
  // ***************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rdv(STATUS_OFS);
    chk("status rst", 32'(STATUS_RST), rd);
    rdv(STACK_OFS);
    chk("stack rst", 32'h0, rd);
    wr(8'h1C, 32'hFFFF_FFFF);
    rdv(8'h1C);
    chk("unmapped", 32'h0, rd);
    rdv(INSTR_OFS);
    chk("instr read", 32'h0, rd);
    for (i = 0; i < FILE_N; i++) begin
      fv[i] = 8'($random(seed));
      wr(fadr(5'(i)), 32'(fv[i]));
    end
    for (i = 0; i < 16; i++) begin
      f = 5'($random(seed));
      d = i[0];
      acc = (i < 2) ? 8'h00 : 8'($random(seed));
      pg = 2'($random(seed));
      st = {1'b0, pg, 2'h3, ~i[1], 2'h0};
      wr(ACC_OFS, 32'(acc));
      wr(STATUS_OFS, 32'(st));
      wr(INSTR_OFS, ins(and_accumulator_file, f, d, 3'h0, 8'h00));
      v = acc & fv[f];
      if (d)
        fv[f] = v;
      else
        acc = v;
      st[ZERO_BIT] = zf(v);
      rdv(ACC_OFS);
      chk("and acc", 32'(acc), rd);
      rdv(fadr(f));
      chk("and file", 32'(fv[f]), rd);
      rdv(STATUS_OFS);
      chk("and status", 32'(st), rd);
    end
    for (i = 0; i < 16; i++) begin
      op = i[0] ? bit_test_skip_set : bit_test_skip_clear;
      f = (i == 15) ? 5'd31 : 5'($random(seed));
      pc = 11'($random(seed));
      s = i[0] ? fv[f][i[3:1]] : !fv[f][i[3:1]];
      wr(PC_OFS, 32'(pc));
      wr(INSTR_OFS, ins(op, f, 1'b0, i[3:1], 8'h00));
      pc = pc + (s ? 11'h2 : 11'h1);
      rdv(PC_OFS);
      chk("skip pc", 32'(pc), rd);
      rdv(EXEC_OFS);
      k = {5'h00, s, s ? TWO_CYCLE : ONE_CYCLE};
      chk("skip cycles", 32'(k), rd);
      rdv(STATUS_OFS);
      chk("skip flags", 32'(st), rd);
    end
    for (i = 0; i < 2; i++) begin
      v = i[0] ? fadr(5'd31) : ACC_OFS;
      op = i[0] ? clear_file_op : clear_accumulator_op;
      st[ZERO_BIT] = 1'b0;
      wr(v, 32'hFF);
      wr(STATUS_OFS, 32'(st));
      wr(INSTR_OFS, ins(op, 5'd31, 1'b0, 3'h0, 8'h00));
      st[ZERO_BIT] = 1'b1;
      rdv(v);
      chk("clear value", 32'h0, rd);
      rdv(STATUS_OFS);
      chk("clear status", 32'(st), rd);
    end
    wr(PC_OFS, 32'h0);
    wb(1'b1, INSTR_OFS, ins(idle_op, 5'h0, 1'b0, 3'h0, 8'h00), 4'h1);
    wr(INSTR_OFS, ins(idle_op, 5'h0, 1'b0, 3'h0, 8'h00));
    rdv(PC_OFS);
    chk("idle pc", 32'h1, rd);
    fill = 0;
    for (i = 0; i < 4; i++) begin
      pc = 11'($random(seed));
      pg = 2'($random(seed));
      k = (i == 0) ? 8'hFF : 8'($random(seed));
      st = {1'b0, pg, 2'h3, i[0], 2'h0};
      wr(PC_OFS, 32'(pc));
      wr(STATUS_OFS, 32'(st));
      wr(INSTR_OFS, ins(call_op, 5'h0, 1'b0, 3'h0, k));
      fill = (fill < STACK_N) ? fill + 1 : fill;
      rdv(PC_OFS);
      chk("call pc", {21'h0, pg, 1'b0, k}, rd);
      rdv(STACK_OFS);
      chk("call stack", {13'h0, 8'(fill), 11'(pc + 11'h1)}, rd);
      rdv(STATUS_OFS);
      chk("call flags", 32'(st), rd);
    end
    for (i = 0; i < 2; i++) begin
      wr(STATUS_OFS, 32'h0);
      repeat (100) @(posedge clk_i);
      if (i == 1)
        wb(1'b1, WDOG_OFS, 32'h0, 4'h4);
      wr(INSTR_OFS, ins(watchdog_kick_op, 5'h0, 1'b0, 3'h0, 8'h00));
      rdv(WDOG_OFS);
      chk("wdog count", 32'h1, 32'(rd[7:0] < 16));
      chk("prescaler", 32'(i == 0), 32'(rd[15:8] < 16));
      rdv(STATUS_OFS);
      chk("kick status", 32'h18, rd);
    end
    final_report;
  end
endmodule
